// ---- shared/akg_defines.vh ----
`ifndef AKG_DEFINES_VH
`define AKG_DEFINES_VH

// widths of the key, vector and cipher block
`define AKG_KEY_BITS     128
`define AKG_KEY_LEN_W    8
`define AKG_IV_BITS      64
`define AKG_IV_LEN_W     7
`define AKG_BLK_BITS     128
`define AKG_BLK_IDX_W    7
`define AKG_BLK_LAST     7'h7f
`define AKG_CTR_BITS     64

// keystream length limits
`define AKG_KS_LEN_W     13
`define AKG_KS_MAX       13'h12e8
`define AKG_SEQ_PER_USE  2

// legacy key is eight bytes
`define AKG_LEGACY_BYTES 8
`define AKG_LEGACY_LEN   8'h40
`define AKG_FULL_LEN     8'h80

`endif

// ---- core/akg_key_map.v ----
`timescale 1ns/10ps
`default_nettype none
`include "akg_defines.vh"

module akg_key_map
(
  input  wire                        key_mode_in,
  input  wire [`AKG_KEY_BITS-1:0]    derived_session_key_in,
  input  wire [`AKG_KEY_LEN_W-1:0]   key_len_in,
  output wire [`AKG_KEY_BITS-1:0]    cipher_key_out,
  output wire [`AKG_KEY_LEN_W-1:0]   key_len_out
);

  wire [`AKG_KEY_BITS-1:0] raw_key;

  // legacy mode: eight bytes, last derived byte becomes first key byte
  genvar gb;
  generate
    for (gb = 0; gb < `AKG_KEY_BITS / 8; gb = gb + 1)
    begin : g_byte
      if (gb < `AKG_LEGACY_BYTES)
      begin : g_low
        assign raw_key[gb*8 +: 8] = key_mode_in ?
          derived_session_key_in[gb*8 +: 8] :   // RULE14 RULE15
          derived_session_key_in[(`AKG_LEGACY_BYTES-1-gb)*8 +: 8];     // RULE13
      end
      else
      begin : g_high
        // legacy key holds only the first 64 derived bits
        assign raw_key[gb*8 +: 8] = key_mode_in ?
          derived_session_key_in[gb*8 +: 8] : 8'h00;                  // RULE12
      end
    end
  endgenerate

  assign key_len_out = key_mode_in ? key_len_in : `AKG_LEGACY_LEN;

  // positions at or beyond the key length are forced to zero
  genvar gi;
  generate
    for (gi = 0; gi < `AKG_KEY_BITS; gi = gi + 1)
    begin : g_mask
      localparam [`AKG_KEY_LEN_W-1:0] IDX = gi;
      assign cipher_key_out[gi] = raw_key[gi] & (key_len_out > IDX); // RULE5
    end
  endgenerate

endmodule
`default_nettype wire

// ---- core/akg_keystream_gen.v ----
`timescale 1ns/10ps
`default_nettype none
`include "akg_defines.vh"

// Behaviour
// RULE1: consumer XORs keystream with plaintext
// RULE2: cipher key up to 128 bits
// RULE3: init vector up to 64 bits
// RULE4: two sequences per use, max 4840 bits
// RULE5: key padded with zeros past length
// RULE6: blocks for counter zero to count minus one
// RULE7: plaintext high half is reversed vector
// RULE8: plaintext low half is block index
// RULE9: one AES encryption per block index
// RULE10: keystream bit equals ciphertext bit in order
// RULE11: last block truncated to requested length
// RULE12: legacy key is first 64 derived bits
// RULE13: legacy key bytes reversed in order
// RULE14: 128-bit derived key used unchanged
// RULE15: security fields travel least significant byte first
// RULE16: start pulse in, bits with valid, done
// RULE17: one AES core reused, inputs held stable
module akg_keystream_gen
(
  input  wire                        ref_clk_in,
  input  wire                        rst_n_in,
  input  wire                        start_in,
  input  wire                        key_mode_in,
  input  wire [`AKG_KEY_BITS-1:0]    derived_session_key_in,
  input  wire [`AKG_KEY_LEN_W-1:0]   key_len_in,
  input  wire [`AKG_IV_BITS-1:0]     init_vector_in,
  input  wire [`AKG_IV_LEN_W-1:0]    iv_len_in,
  input  wire [`AKG_KS_LEN_W-1:0]    ks_len_in,
  input  wire                        aes_done_in,
  input  wire [`AKG_BLK_BITS-1:0]    aes_ct_in,
  output wire                        aes_start_out,
  output wire [`AKG_BLK_BITS-1:0]    aes_key_out,
  output wire [`AKG_BLK_BITS-1:0]    aes_pt_out,
  output wire                        keystream_bits_out,
  output wire                        ks_valid_out,
  output wire                        ks_done_out,
  output wire                        seq_sel_out,
  output wire                        busy_out
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_REQ  = 5'h02;
  localparam [4:0] ST_WAIT = 5'h04;
  localparam [4:0] ST_EMIT = 5'h08;
  localparam [4:0] ST_FIN  = 5'h10;

  reg  [4:0]                 state_r;
  reg  [`AKG_BLK_BITS-1:0]   key_r;
  reg  [`AKG_IV_BITS-1:0]    iv_r;
  reg  [`AKG_IV_LEN_W-1:0]   iv_len_r;
  reg  [`AKG_KS_LEN_W-1:0]   len_r;
  reg  [`AKG_CTR_BITS-1:0]   blk_r;
  reg  [`AKG_KS_LEN_W-1:0]   bit_cnt_r;
  reg  [`AKG_BLK_IDX_W-1:0]  bit_idx_r;
  reg  [`AKG_BLK_BITS-1:0]   shift_r;
  reg                        seq_r;
  reg                        aes_start_r;
  reg  [`AKG_BLK_BITS-1:0]   pt_r;
  reg                        ks_bit_r;
  reg                        ks_valid_r;
  reg                        done_r;
  reg                        busy_r;

  wire [`AKG_KEY_BITS-1:0]   ck_map;
  // padded length is applied inside the map, so it is left open here
  wire [`AKG_BLK_BITS-1:0]   key_rev;
  wire [`AKG_IV_BITS-1:0]    iv_masked;
  wire [`AKG_KS_LEN_W-1:0]   len_clamp;
  wire [`AKG_KS_LEN_W-1:0]   len_last;
  wire                       seq_last;

  akg_key_map u_key_map
  (
    .key_mode_in            (key_mode_in),
    .derived_session_key_in (derived_session_key_in),
    .key_len_in             (key_len_in),
    .cipher_key_out         (ck_map),
    .key_len_out            ()
  );

  // key position k sits in aes word bit 127-k, so the word reads in
  // the usual most-significant-first hex order
  genvar gi;
  generate
    for (gi = 0; gi < `AKG_BLK_BITS; gi = gi + 1)
    begin : g_krev
      assign key_rev[`AKG_BLK_BITS-1-gi] = ck_map[gi];                // RULE2
    end
    for (gi = 0; gi < `AKG_IV_BITS; gi = gi + 1)
    begin : g_iv
      localparam [`AKG_IV_LEN_W-1:0] IDX = gi;
      // vector bit i lands at plaintext position 63-i, word bit 64+i
      assign iv_masked[gi] = iv_r[gi] & (iv_len_r > IDX);             // RULE7
    end
  endgenerate

  // overlong requests are cut to the system limit rather than refused
  assign len_clamp = (ks_len_in > `AKG_KS_MAX) ? `AKG_KS_MAX :
                     ks_len_in;                                       // RULE4
  assign len_last  = len_r - {{(`AKG_KS_LEN_W-1){1'b0}}, 1'b1};
  assign seq_last  = (seq_r == 1'b1);

  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r     <= ST_IDLE;
      key_r       <= {`AKG_BLK_BITS{1'b0}};
      iv_r        <= {`AKG_IV_BITS{1'b0}};
      iv_len_r    <= {`AKG_IV_LEN_W{1'b0}};
      len_r       <= {`AKG_KS_LEN_W{1'b0}};
      blk_r       <= {`AKG_CTR_BITS{1'b0}};
      bit_cnt_r   <= {`AKG_KS_LEN_W{1'b0}};
      bit_idx_r   <= {`AKG_BLK_IDX_W{1'b0}};
      shift_r     <= {`AKG_BLK_BITS{1'b0}};
      seq_r       <= 1'b0;
      aes_start_r <= 1'b0;
      pt_r        <= {`AKG_BLK_BITS{1'b0}};
      ks_bit_r    <= 1'b0;
      ks_valid_r  <= 1'b0;
      done_r      <= 1'b0;
      busy_r      <= 1'b0;
    end
    else
    begin
      aes_start_r <= 1'b0;
      ks_valid_r  <= 1'b0;
      done_r      <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          // start is ignored while busy: inputs are latched only here
          if (start_in)                                               // RULE16
          begin
            key_r     <= key_rev;                                     // RULE17
            iv_r      <= init_vector_in;                              // RULE3
            iv_len_r  <= iv_len_in;
            len_r     <= len_clamp;
            blk_r     <= {`AKG_CTR_BITS{1'b0}};                       // RULE6
            bit_cnt_r <= {`AKG_KS_LEN_W{1'b0}};
            seq_r     <= 1'b0;
            busy_r    <= 1'b1;
            if (len_clamp == {`AKG_KS_LEN_W{1'b0}})
              state_r <= ST_FIN;
            else
              state_r <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          pt_r        <= {iv_masked, blk_r};                          // RULE8
          aes_start_r <= 1'b1;                                        // RULE9
          state_r     <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (aes_done_in)
          begin
            shift_r   <= aes_ct_in;
            bit_idx_r <= {`AKG_BLK_IDX_W{1'b0}};
            state_r   <= ST_EMIT;
          end
        end
        ST_EMIT:
        begin
          // ciphertext position i is aes word bit 127-i, sent first
          ks_bit_r   <= shift_r[`AKG_BLK_BITS-1];                     // RULE10
          ks_valid_r <= 1'b1;
          shift_r    <= {shift_r[`AKG_BLK_BITS-2:0], 1'b0};
          bit_cnt_r  <= bit_cnt_r + {{(`AKG_KS_LEN_W-1){1'b0}}, 1'b1};
          bit_idx_r  <= bit_idx_r + {{(`AKG_BLK_IDX_W-1){1'b0}}, 1'b1};
          if (bit_cnt_r == len_last)
            state_r <= ST_FIN;                                        // RULE11
          else if (bit_idx_r == `AKG_BLK_LAST)
          begin
            blk_r   <= blk_r + {{(`AKG_CTR_BITS-1){1'b0}}, 1'b1};     // RULE6
            state_r <= ST_REQ;
          end
        end
        ST_FIN:
        begin
          done_r <= 1'b1;                                             // RULE16
          if (seq_last)
          begin
            busy_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
          else
          begin
            // second sequence restarts the counter from zero
            seq_r     <= 1'b1;                                        // RULE4
            blk_r     <= {`AKG_CTR_BITS{1'b0}};
            bit_cnt_r <= {`AKG_KS_LEN_W{1'b0}};
            if (len_r == {`AKG_KS_LEN_W{1'b0}})
              state_r <= ST_FIN;
            else
              state_r <= ST_REQ;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  assign aes_start_out      = aes_start_r;
  assign aes_key_out        = key_r;
  assign aes_pt_out         = pt_r;
  assign keystream_bits_out = ks_bit_r;
  assign ks_valid_out       = ks_valid_r;
  assign ks_done_out        = done_r;
  assign seq_sel_out        = seq_r;
  assign busy_out           = busy_r;

endmodule
`default_nettype wire

// ---- verif/akg_keystream_gen_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module akg_keystream_gen_assertions
(
  input wire logic         ref_clk_in,
  input wire logic         rst_n_in,
  input wire logic         start_in,
  input wire logic         aes_done_in,
  input wire logic         aes_start_out,
  input wire logic [127:0] aes_key_out,
  input wire logic [127:0] aes_pt_out,
  input wire logic         ks_valid_out,
  input wire logic         ks_done_out,
  input wire logic         seq_sel_out,
  input wire logic         busy_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_take; start_in && !busy_out |=> busy_out; endproperty
  property p_first; $rose(busy_out) |=>
    (aes_start_out && aes_pt_out[63:0] == 64'h0) || ks_done_out;
  endproperty
  property p_req; aes_start_out |=> !aes_start_out; endproperty
  property p_bit; aes_done_in |-> ##2 ks_valid_out; endproperty
  property p_done; ks_done_out |=> !ks_done_out || !busy_out; endproperty
  property p_key; busy_out && $past(busy_out) && $past(busy_out, 2)
    |-> $stable(aes_key_out); endproperty
  property p_pt; !aes_start_out && busy_out && $past(busy_out)
    |-> $stable(aes_pt_out); endproperty
  property p_seq; $rose(seq_sel_out) |-> ks_done_out; endproperty
  property p_end; $fell(busy_out) |-> ks_done_out && seq_sel_out;
  endproperty
  property p_vbusy; ks_valid_out |-> busy_out; endproperty
  a_take: assert property (p_take) else $error("start lost");
  a_first: assert property (p_first) else $error("bad first");
  a_req: assert property (p_req) else $error("long request");
  a_bit: assert property (p_bit) else $error("no bit");
  a_done: assert property (p_done) else $error("long done");
  a_key: assert property (p_key) else $error("key moved");
  a_pt: assert property (p_pt) else $error("block moved");
  a_seq: assert property (p_seq) else $error("seq early");
  a_end: assert property (p_end) else $error("bad end");
  a_vbusy: assert property (p_vbusy) else $error("idle bit");
  c_fast: cover property (aes_start_out ##1 aes_done_in);
  c_two: cover property (ks_done_out && seq_sel_out);
  c_end: cover property ($fell(busy_out));
endmodule
`default_nettype wire

// ---- verif/akg_aes_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module akg_aes_model
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         start_in,
  input  wire logic [127:0] key_in,
  input  wire logic [127:0] pt_in,
  input  wire logic [3:0]   lat_in,
  output var  logic         done_out,
  output var  logic [127:0] ct_out
);
  logic [3:0] cnt_r;
  // stand-in cipher; key and block are held by the generator meanwhile
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt_r <= 4'h0;
      done_out <= 1'b0;
      ct_out <= 128'h0;
    end
    else
    begin
      cnt_r <= start_in ? lat_in : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
      done_out <= start_in ? (lat_in == 4'h0) : (cnt_r == 4'h1);
      if (start_in ? (lat_in == 4'h0) : (cnt_r == 4'h1))
        ct_out <= pt_in ^ {key_in[63:0], key_in[127:64]};
      else
        ct_out <= ~ct_out;
    end
endmodule
`default_nettype wire

// ---- verif/akg_keystream_gen_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module akg_keystream_gen_tb;
  logic ref_clk_in = 0, rst_n_in = 0, start_in = 0, key_mode_in = 0;
  logic [127:0] derived_session_key_in = 0, aes_ct_in, aes_key_out;
  logic [127:0] aes_pt_out, kexp, pj;
  logic [7:0] key_len_in = 0;
  logic [63:0] init_vector_in = 0, ivm;
  logic [6:0] iv_len_in = 0;
  logic [12:0] ks_len_in = 0;
  logic [3:0] lat = 0;
  logic aes_done_in, aes_start_out, keystream_bits_out, ks_valid_out;
  logic ks_done_out, seq_sel_out, busy_out;
  integer miscompares = 0, n_compared = 0, blk, nbit, ndone, elen;
  akg_keystream_gen dut_u (.ref_clk_in, .rst_n_in, .start_in,
    .key_mode_in, .derived_session_key_in, .key_len_in,
    .init_vector_in, .iv_len_in, .ks_len_in, .aes_done_in, .aes_ct_in,
    .aes_start_out, .aes_key_out, .aes_pt_out, .keystream_bits_out,
    .ks_valid_out, .ks_done_out, .seq_sel_out, .busy_out);
  akg_aes_model aes_u (.clk_in(ref_clk_in), .rst_n_in,
    .start_in(aes_start_out), .key_in(aes_key_out), .pt_in(aes_pt_out),
    .lat_in(lat), .done_out(aes_done_in), .ct_out(aes_ct_in));
  initial forever #20 ref_clk_in = ~ref_clk_in;
  task stop_test;
    $display("miscompares %0d n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // keystream is checked here, bit by bit, as it streams out
  always @(posedge ref_clk_in)
    if (rst_n_in)
    begin
      if (aes_start_out)
      begin
        chk(aes_key_out, kexp);
        chk(aes_pt_out, {ivm, 64'(blk)});
        blk++;
      end
      if (ks_valid_out)
      begin
        pj = {ivm, 64'(nbit / 128)};
        pj = pj ^ {kexp[63:0], kexp[127:64]};
        chk(keystream_bits_out, pj[127 - nbit % 128]);
        chk(seq_sel_out, 128'(ndone));
        nbit++;
      end
      if (ks_done_out)
      begin
        chk(nbit, elen);
        chk(blk, (elen + 127) / 128);
        nbit = 0;
        blk = 0;
        ndone++;
      end
    end
  task run(input m, input [127:0] k, input [7:0] kl, input [63:0] iv,
    input [6:0] il, input [12:0] ln, input [3:0] lt, input poke);
    integer i, w;
    begin
      kexp = 0;
      for (i = 0; i < (m ? (kl > 128 ? 128 : kl) : 64); i++)
        kexp[127 - i] = m ? k[i] : k[8 * (7 - i / 8) + i % 8];
      ivm = 0;
      for (i = 0; i < il && i < 64; i++)
        ivm[i] = iv[i];
      elen = ln > 4840 ? 4840 : ln;
      ndone = 0;
      nbit = 0;
      blk = 0;
      @(negedge ref_clk_in);
      {key_mode_in, derived_session_key_in, key_len_in} = {m, k, kl};
      {init_vector_in, iv_len_in, ks_len_in, lat} = {iv, il, ln, lt};
      start_in = 1;
      w = 0;
      do
      begin
        @(negedge ref_clk_in);
        w++;
        start_in = poke && w == 300;
        if (poke && w == 300)
          derived_session_key_in = ~k;
      end
      while (busy_out === 1'b1 && w < 30000);
      if (w >= 30000)
      begin
        miscompares++;
        stop_test;
      end
      // busy falls with the final done, so let that pulse be counted
      @(negedge ref_clk_in);
      chk(ndone, 2);
    end
  endtask
  task t_full;
    run(1, 128'h5e9d489c191661726b7232e6401d71f0, 8'h80,
      64'h03847f4f494a0677, 7'h40, 13'd720, 4'd0, 0);
  endtask
  task t_pad;
    run(1, 128'hc3d25e38117444ed4761f67adb94f80e, 8'd100,
      64'h96bd2862c715fc88, 7'd40, 13'd128, 4'd6, 0);
  endtask
  task t_legacy;
    run(0, 128'h01a063ba8e8a07cf063c6e233405f14e, 8'd20,
      64'h6ba2802b910ff339, 7'd64, 13'd129, 4'd1, 0);
  endtask
  task t_limits;
    run(1, 128'h0, 8'hff, 64'h0, 7'h7f, 13'd0, 4'd0, 0);
    run(1, 128'h00010203040506070809, 8'hff, 64'hffffffff00000001,
      7'h7f, 13'h1fff, 4'd2, 1);
  endtask
  initial
  begin
    repeat (10) @(negedge ref_clk_in);
    rst_n_in = 1;
    t_full;
    t_pad;
    t_legacy;
    t_limits;
    stop_test;
  end
endmodule
bind akg_keystream_gen akg_keystream_gen_assertions chk_u (.ref_clk_in,
  .rst_n_in, .start_in, .aes_done_in, .aes_start_out, .aes_key_out,
  .aes_pt_out, .ks_valid_out, .ks_done_out, .seq_sel_out, .busy_out);
`default_nettype wire
